// ---- xdata_defs.svh ----
// constants for the external-data ram access and identification block
`ifndef XDATA_DEFS_SVH
`define XDATA_DEFS_SVH

`define XD_PAGE_ALL         4'h0
`define XD_PAGE_ID          4'hF
`define XD_ADDR_PAGE_SELECT 8'hB9
`define XD_ADDR_PTR_LOW     8'h82
`define XD_ADDR_PTR_HIGH    8'h83
`define XD_ADDR_FAMILY      8'hE1
`define XD_ADDR_REVISION    8'hE2
`define XD_RST_PAGE_SELECT  8'h00
`define XD_RST_PTR          16'h0000
`define XD_RAM_AW           13
`define XD_KEY_BASE         13'h1FF0
`define XD_KEY_BYTES        16

`endif

// ---- xdata_pkg.sv ----
// types shared by the external-data ram access block
package xdata_pkg;
  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } xaccess_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] page;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;
endpackage

// ---- xdata_ram.sv ----
// single-port byte memory with registered read data
`timescale 1ns/1ps
`include "xdata_defs.svh"
module xdata_ram (
  input  wire logic                    mclk_i,  // system clock
  input  wire logic                    ce_i,    // clock enable
  input  wire logic                    en_i,    // access strobe
  input  wire logic                    we_i,    // write when high
  input  wire logic [`XD_RAM_AW-1:0]   addr_i,  // byte address
  input  wire logic [7:0]              wdata_i, // write byte
  output logic      [7:0]              rdata_o  // read byte, registered
);
  logic [7:0] mem [0:(1<<`XD_RAM_AW)-1];

  always_ff @(posedge mclk_i) begin
    if (ce_i && en_i && we_i) begin
      mem[addr_i] <= wdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (ce_i && en_i) begin
      rdata_o <= mem[addr_i];
    end
  end
endmodule

// ---- xdata_ram_access.sv ----
// external-data ram access with page select, data pointer, unique key and id registers
`timescale 1ns/1ps
`include "xdata_defs.svh"
module xdata_ram_access #(
  parameter logic [127:0] UNIQUE_KEY = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210,
  parameter logic [7:0]   FAMILY     = 8'h5A, // arbitrary value
  parameter logic [7:0]   REVISION   = 8'h01  // arbitrary value
) (
  input  wire logic              mclk_i,       // system clock, 125 MHz
  input  wire logic              rst_i,        // synchronous reset, active high
  input  wire logic              ce_i,         // clock enable, freezes state when low
  input  xdata_pkg::sfr_req_t    sfr_i,        // register access from core
  output logic [7:0]             sfr_rdata_o,  // register read data
  input  wire logic              movx_req_i,   // core data move request
  input  wire logic              movx_we_i,    // core move is a write
  input  wire logic              movx_wide_i,  // 1: pointer form, 0: page+index form
  input  wire logic [7:0]        movx_idx_i,   // index register value for narrow form
  input  wire logic [7:0]        movx_wdata_i, // core write byte
  output logic                   movx_ack_o,   // move done pulse
  output logic [7:0]             movx_rdata_o, // core read byte
  input  wire logic              dbg_rd_i,     // debug read request, held until ack
  input  wire logic [15:0]       dbg_addr_i,   // debug read address
  output logic                   dbg_ack_o,    // debug read done pulse
  output logic [7:0]             dbg_rdata_o   // debug read byte
);
  // ****************************************************
  // register file
  // ****************************************************
  logic [7:0]  page_high_byte_q;
  logic [15:0] wide_pointer_q;
  logic        wr_sel_page;
  logic        wr_sel_ptr_lo;
  logic        wr_sel_ptr_hi;

  assign wr_sel_page   = sfr_i.wr && sfr_i.page == `XD_PAGE_ALL
                         && sfr_i.addr == `XD_ADDR_PAGE_SELECT;
  assign wr_sel_ptr_lo = sfr_i.wr && sfr_i.addr == `XD_ADDR_PTR_LOW;
  assign wr_sel_ptr_hi = sfr_i.wr && sfr_i.addr == `XD_ADDR_PTR_HIGH;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      page_high_byte_q <= `XD_RST_PAGE_SELECT;
    end else if (ce_i && wr_sel_page) begin
      page_high_byte_q <= sfr_i.wdata;
    end
  end

  // pointer bytes are visible on every register page
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wide_pointer_q <= `XD_RST_PTR;
    end else if (ce_i) begin
      if (wr_sel_ptr_lo) begin
        wide_pointer_q[7:0] <= sfr_i.wdata;
      end
      if (wr_sel_ptr_hi) begin
        wide_pointer_q[15:8] <= sfr_i.wdata;
      end
    end
  end

  // id registers have no write path at all, so writes fall away
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (ce_i && sfr_i.rd) begin
      if (sfr_i.addr == `XD_ADDR_PTR_LOW) begin
        sfr_rdata_o <= wide_pointer_q[7:0];
      end else if (sfr_i.addr == `XD_ADDR_PTR_HIGH) begin
        sfr_rdata_o <= wide_pointer_q[15:8];
      end else if (sfr_i.page == `XD_PAGE_ALL && sfr_i.addr == `XD_ADDR_PAGE_SELECT) begin
        sfr_rdata_o <= page_high_byte_q;
      end else if (sfr_i.page == `XD_PAGE_ID && sfr_i.addr == `XD_ADDR_FAMILY) begin
        sfr_rdata_o <= FAMILY;
      end else if (sfr_i.page == `XD_PAGE_ID && sfr_i.addr == `XD_ADDR_REVISION) begin
        sfr_rdata_o <= REVISION;
      end else begin
        sfr_rdata_o <= 8'h00;
      end
    end
  end

  // ****************************************************
  // address formation and arbitration
  // ****************************************************
  xdata_pkg::xaccess_t acc;
  logic                acc_en;
  logic                dbg_grant;
  logic                hit_key;
  logic [3:0]          key_idx;

  // core has priority; debug waits for as long as movx_req_i stays high
  assign dbg_grant = dbg_rd_i && !movx_req_i;
  assign acc_en    = movx_req_i || dbg_rd_i;

  always_comb begin
    acc.we    = movx_req_i && movx_we_i;
    acc.wdata = movx_wdata_i;
    if (!movx_req_i) begin
      acc.addr = dbg_addr_i;
    end else if (movx_wide_i) begin
      acc.addr = wide_pointer_q;
    end else begin
      acc.addr = {page_high_byte_q, movx_idx_i};
    end
  end

  // a literal cannot be part-selected, so the key base is held as a named constant
  localparam logic [`XD_RAM_AW-1:0] KEY_BASE = `XD_KEY_BASE;

  // upper address bits beyond the ram alias onto it
  assign hit_key = acc.addr[`XD_RAM_AW-1:4] == KEY_BASE[`XD_RAM_AW-1:4];
  assign key_idx = acc.addr[3:0];

  // ****************************************************
  // unique key bytes
  // ****************************************************
  logic [7:0] key_q [0:`XD_KEY_BYTES-1];

  genvar gi;
  generate
    for (gi = 0; gi < `XD_KEY_BYTES; gi++) begin : g_key
      always_ff @(posedge mclk_i) begin
        if (rst_i) begin
          key_q[gi] <= UNIQUE_KEY[gi*8 +: 8];
        end else if (ce_i && acc_en && acc.we && hit_key && key_idx == 4'(gi)) begin
          key_q[gi] <= acc.wdata;
        end
      end
    end
  endgenerate

  // ****************************************************
  // ram and read return
  // ****************************************************
  logic [7:0] ram_rdata;
  logic [7:0] key_rdata_q;
  logic       key_sel_q;
  logic       core_q;
  logic       core_rd_q;
  logic       dbg_q;

  xdata_ram u_ram (
    .mclk_i  (mclk_i),
    .ce_i    (ce_i),
    .en_i    (acc_en && !hit_key),
    .we_i    (acc.we),
    .addr_i  (acc.addr[`XD_RAM_AW-1:0]),
    .wdata_i (acc.wdata),
    .rdata_o (ram_rdata)
  );

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      key_rdata_q <= 8'h00;
      key_sel_q   <= 1'b0;
      core_q      <= 1'b0;
      core_rd_q   <= 1'b0;
      dbg_q       <= 1'b0;
    end else if (ce_i) begin
      key_rdata_q <= key_q[key_idx];
      key_sel_q   <= hit_key;
      core_q      <= movx_req_i;
      core_rd_q   <= movx_req_i && !movx_we_i;
      dbg_q       <= dbg_grant;
    end
  end

  logic [7:0] rd_byte;
  assign rd_byte = key_sel_q ? key_rdata_q : ram_rdata;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      movx_rdata_o <= 8'h00;
      dbg_rdata_o  <= 8'h00;
    end else if (ce_i) begin
      // only reads load the byte; a write would otherwise overwrite it with the old cell
      if (core_rd_q) begin
        movx_rdata_o <= rd_byte;
      end
      if (dbg_q) begin
        dbg_rdata_o <= rd_byte;
      end
    end
  end

  // ack flags one cycle before the data register holds it is avoided:
  // acks come from the same stage as the data
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      movx_ack_o <= 1'b0;
      dbg_ack_o  <= 1'b0;
    end else if (ce_i) begin
      movx_ack_o <= core_q;
      dbg_ack_o  <= dbg_q;
    end
  end
endmodule

// ---- xdata_ram_access_props.sv ----
// assertion checker for the external-data ram access block
`timescale 1ns/1ps
module xdata_ram_access_props #(
  parameter logic [7:0] FAMILY = 8'h5A // arbitrary value
) (
  input  wire logic          mclk_i,       // clock
  input  wire logic          rst_i,        // reset
  input  wire logic          ce_i,         // clock enable
  input  xdata_pkg::sfr_req_t sfr_i,        // register access
  input  wire logic [7:0]    sfr_rdata_o,  // register data
  input  wire logic          movx_req_i,   // move request
  input  wire logic          movx_we_i,    // move write
  input  wire logic          movx_ack_o,   // move done
  input  wire logic [7:0]    movx_rdata_o, // move data
  input  wire logic          dbg_rd_i,     // debug request
  input  wire logic          dbg_ack_o     // debug done
);
  logic [7:0] page_q; // shadow of the page select
  always_ff @(posedge mclk_i) begin
    if (rst_i) page_q <= 8'h00;
    else if (ce_i && sfr_i.wr && sfr_i.page == 4'h0 && sfr_i.addr == 8'hB9) page_q <= sfr_i.wdata;
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  move_ack_a: assert property (movx_req_i |-> ##2 movx_ack_o)
    else $error("move ack late");
  ack_cause_a: assert property (movx_ack_o |-> $past(movx_req_i, 2))
    else $error("move ack without request");
  dbg_ack_a: assert property (dbg_rd_i && !movx_req_i |-> ##2 dbg_ack_o)
    else $error("debug ack late");
  dbg_stall_a: assert property (movx_req_i |-> ##2 !dbg_ack_o)
    else $error("debug served over core");
  page_rd_a: assert property (sfr_i.rd && !sfr_i.wr && sfr_i.page == 4'h0 &&
    sfr_i.addr == 8'hB9 |=> sfr_rdata_o == page_q) else $error("page select readback");
  family_rd_a: assert property (sfr_i.rd && sfr_i.page == 4'hF &&
    sfr_i.addr == 8'hE1 |=> sfr_rdata_o == FAMILY) else $error("family code wrong");
  rdata_hold_a: assert property (!sfr_i.rd |=> $stable(sfr_rdata_o))
    else $error("register data moved");
  mdata_hold_a: assert property ($changed(movx_rdata_o) |-> movx_ack_o &&
    !$past(movx_we_i, 2)) else $error("move data moved");
  cover property (movx_ack_o && !$past(movx_we_i, 2));
  cover property (dbg_ack_o);
  cover property (sfr_i.rd && sfr_i.addr == 8'hE1);
endmodule

bind xdata_ram_access xdata_ram_access_props #(.FAMILY(FAMILY)) u_props (
  .mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i), .sfr_i(sfr_i), .sfr_rdata_o(sfr_rdata_o),
  .movx_req_i(movx_req_i), .movx_we_i(movx_we_i), .movx_ack_o(movx_ack_o),
  .movx_rdata_o(movx_rdata_o), .dbg_rd_i(dbg_rd_i), .dbg_ack_o(dbg_ack_o));

// ---- core_model.sv ----
// behavioural processor core issuing external-data moves
`timescale 1ns/1ps
module core_model (
  input  wire logic       mclk_i,  // clock
  input  wire logic       ack_i,   // move done
  input  wire logic [7:0] rdata_i, // read byte
  output logic            req_o,   // move request
  output logic            we_o,    // write when high
  output logic            wide_o,  // pointer form
  output logic [7:0]      idx_o,   // index register
  output logic [7:0]      wdata_o  // write byte
);
  initial begin
    req_o = 1'b0;
    we_o = 1'b0;
    wide_o = 1'b0;
    idx_o = 8'h00;
    wdata_o = 8'h00;
  end
  // idle index and write-data lines show the inverse of the last value so stale data cannot pass
  task automatic move(input logic we, wide, input logic [7:0] ix, d, output logic [7:0] rd);
    @(posedge mclk_i);
    req_o <= 1'b1;
    we_o <= we;
    wide_o <= wide;
    idx_o <= ix;
    wdata_o <= d;
    @(posedge mclk_i);
    req_o <= 1'b0;
    idx_o <= ~ix;
    wdata_o <= ~d;
    @(posedge mclk_i);
    #1 rd = ack_i ? rdata_i : 8'hxx;
  endtask
endmodule

// ---- tb_xdata_ram_access.sv ----
// self-checking testbench for the external-data ram access block
`timescale 1ns/1ps
module tb_xdata_ram_access;
  localparam logic [127:0] KEY = 128'hF1E2_D3C4_B5A6_9788_7968_5A4B_3C2D_1E0F;
  localparam logic [7:0]   FAM = 8'h3C; // arbitrary value
  localparam logic [7:0]   REV = 8'h07; // arbitrary value
  logic                mclk_i = 1'b0;
  logic                rst_i = 1'b1;
  logic                ce_i = 1'b1;
  xdata_pkg::sfr_req_t sfr_i = '0;
  logic                dbg_rd_i = 1'b0;
  logic [15:0]         dbg_addr_i = 16'h0000;
  logic [7:0]          sfr_rdata_o, movx_rdata_o, dbg_rdata_o, idx, wd, rd;
  logic                movx_req_i, movx_we_i, movx_wide_i, movx_ack_o, dbg_ack_o;
  int                  mismatches = 0;
  int                  n_tests = 0;
  initial forever #4 mclk_i = ~mclk_i;
  xdata_ram_access #(.UNIQUE_KEY(KEY), .FAMILY(FAM), .REVISION(REV)) u_dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i), .sfr_i(sfr_i), .sfr_rdata_o(sfr_rdata_o),
    .movx_req_i(movx_req_i), .movx_we_i(movx_we_i), .movx_wide_i(movx_wide_i),
    .movx_idx_i(idx), .movx_wdata_i(wd), .movx_ack_o(movx_ack_o), .movx_rdata_o(movx_rdata_o),
    .dbg_rd_i(dbg_rd_i), .dbg_addr_i(dbg_addr_i), .dbg_ack_o(dbg_ack_o),
    .dbg_rdata_o(dbg_rdata_o));
  core_model u_core (.mclk_i(mclk_i), .ack_i(movx_ack_o), .rdata_i(movx_rdata_o),
    .req_o(movx_req_i), .we_o(movx_we_i), .wide_o(movx_wide_i), .idx_o(idx), .wdata_o(wd));
  task automatic chk(input logic [7:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // a read compares its data against d
  task automatic sfr(input logic wr, input logic [3:0] pg, input logic [7:0] a, d);
    @(posedge mclk_i);
    sfr_i <= '{wr, !wr, pg, a, d};
    @(posedge mclk_i);
    sfr_i <= '0;
    #1;
    if (!wr) chk(sfr_rdata_o, d);
  endtask
  task automatic mv(input logic we, wide, input logic [7:0] ix, d, exp);
    u_core.move(we, wide, ix, d, rd);
    if (!we) chk(rd, exp);
  endtask
  task automatic dbg(input logic [15:0] a, input logic [7:0] exp);
    @(posedge mclk_i);
    dbg_rd_i <= 1'b1;
    dbg_addr_i <= a;
    @(posedge mclk_i);
    dbg_rd_i <= 1'b0;
    @(posedge mclk_i);
    #1 chk(dbg_ack_o ? dbg_rdata_o : 8'hxx, exp);
  endtask
  task automatic do_reset;
    @(posedge mclk_i);
    rst_i <= 1'b1;
    repeat (6) @(posedge mclk_i);
    rst_i <= 1'b0;
  endtask
  task automatic end_sim;
    $display("tests=%0d mismatches=%0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge mclk_i);
    mismatches++;
    end_sim();
  end
  initial begin
    do_reset();
    sfr(0, 4'h0, 8'hB9, 8'h00);
    sfr(0, 4'hF, 8'hE1, FAM);
    sfr(0, 4'hF, 8'hE2, REV);
    sfr(1, 4'hF, 8'hE1, 8'hFF);
    sfr(0, 4'hF, 8'hE1, FAM);
    sfr(0, 4'hF, 8'hB9, 8'h00);
    sfr(1, 4'h0, 8'h83, 8'h1F);
    sfr(1, 4'h0, 8'h82, 8'hFF);
    mv(0, 1, 8'h00, 8'h00, KEY[127:120]);
    for (int i = 0; i < 16; i++) dbg(16'h1FF0 + 16'(i), KEY[8*i +: 8]);
    mv(1, 1, 8'h00, 8'h77, 8'h00);
    mv(0, 1, 8'h00, 8'h00, 8'h77);
    sfr(1, 4'h0, 8'hB9, 8'h12);
    sfr(0, 4'h0, 8'hB9, 8'h12);
    // a write while the clock enable is low must not land
    @(posedge mclk_i) ce_i <= 1'b0;
    sfr(1, 4'h0, 8'hB9, 8'h55);
    @(posedge mclk_i) ce_i <= 1'b1;
    sfr(0, 4'h0, 8'hB9, 8'h12);
    sfr(1, 4'h0, 8'h83, 8'h12);
    sfr(1, 4'h0, 8'h82, 8'h34);
    sfr(0, 4'h5, 8'h83, 8'h12);
    mv(1, 1, 8'h00, 8'hA5, 8'h00);
    mv(0, 0, 8'h34, 8'h00, 8'hA5);
    mv(1, 0, 8'hFF, 8'h3C, 8'h00);
    sfr(1, 4'h0, 8'h82, 8'hFF);
    mv(0, 1, 8'h00, 8'h00, 8'h3C);
    do_reset();
    sfr(0, 4'h0, 8'hB9, 8'h00);
    sfr(0, 4'h0, 8'h83, 8'h00);
    sfr(1, 4'h0, 8'h83, 8'h1F);
    sfr(1, 4'h0, 8'h82, 8'hFF);
    mv(0, 1, 8'h00, 8'h00, KEY[127:120]);
    sfr(1, 4'h0, 8'h83, 8'h12);
    sfr(1, 4'h0, 8'h82, 8'h34);
    mv(0, 1, 8'h00, 8'h00, 8'hA5);
    end_sim();
  end
endmodule
